// File: hdl/ssio_pkg.sv
/*
 * ssio_pkg: shared constants of the 8-bit synchronous serial unit:
 * register offsets, field positions, reset values, clock codes, states.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package ssio_pkg;

	// register byte offsets, one aligned word each
	localparam logic [3:0] OFF_CTRL   = 4'h0; // serial_control_reg
	localparam logic [3:0] OFF_STAT   = 4'h4; // serial_status_reg
	localparam logic [3:0] OFF_TXBUF  = 4'h8; // transmit_buffer
	localparam logic [3:0] OFF_RXBUF  = 4'hc; // receive_buffer

	// control field positions
	localparam int CTRL_START     = 0; // transfer_start_bit
	localparam int CTRL_INHIBIT   = 1; // forced_stop_bit
	localparam int CTRL_MODE_LO   = 2; // transfer_mode_field, 2 bits
	localparam int CTRL_MODE_HI   = 3;
	localparam int CTRL_ORDER     = 4; // bit_order_select
	localparam int CTRL_CLK_LO    = 5; // clock source code, 3 bits
	localparam int CTRL_CLK_HI    = 7;

	// status field positions
	localparam int STAT_BUSY      = 0; // transfer_busy_flag
	localparam int STAT_SHIFT     = 1; // shift_active_flag
	localparam int STAT_TXEMPTY   = 2; // transmit_empty_flag
	localparam int STAT_RXFULL    = 3; // receive_full_flag
	localparam int STAT_TRANSMIT_ERROR_FLAG     = 4; // transmit_error_flag
	localparam int STAT_RECEIVE_ERROR_FLAG     = 5; // receive_error_flag

	// transfer modes
	localparam logic [1:0] MODE_TX    = 2'h0;
	localparam logic [1:0] MODE_RX    = 2'h1;
	localparam logic [1:0] MODE_DUPLEX = 2'h2;

	// clock source code selecting the pin as input
	localparam logic [2:0] CLK_EXTERNAL = 3'h7;

	// internal clock: half period in cycles is base shifted by the code
	localparam int SCK_HALF_BASE = 2;
	localparam int SCK_CNT_W     = 9;

	// byte geometry
	localparam int DATA_W        = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// reset and initialise values
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] BUF_RESET    = 8'h00;
	localparam logic       TXEMPTY_INIT = 1'b1;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_SHIFT
	} ssio_state_t;

endpackage : ssio_pkg

// File: hdl/ssio_sckgen.sv
/*
 * ssio_sckgen: internal serial clock generator. Idles high, runs while
 * run_i is high, and reports each edge with a one-cycle pulse.
 * Assumes run_i comes from logic on clk_i; stopping returns it high.
 */
module ssio_sckgen (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	input  wire logic       run_i,
	input  wire logic [2:0] rate_i,
	output logic            sck_o,
	output logic            fall_o,
	output logic            rise_o
);

	logic [ssio_pkg::SCK_CNT_W-1:0] cnt_reg;   // half-period counter
	logic [ssio_pkg::SCK_CNT_W-1:0] half_next; // last count of a half

	// half period from the rate code
	always_comb begin
		half_next = ssio_pkg::SCK_CNT_W'(
			(ssio_pkg::SCK_HALF_BASE << rate_i) - 1);
	end

	// counter and level; parking always restarts a full half period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			sck_o   <= 1'b1;
			fall_o  <= 1'b0;
			rise_o  <= 1'b0;
		end else if (ce_i) begin
			fall_o <= 1'b0;
			rise_o <= 1'b0;
			if (!run_i) begin
				// parked high; a stop during a low phase raises the clock at once
				cnt_reg <= '0;
				if (!sck_o) begin
					sck_o  <= 1'b1;
					rise_o <= 1'b1;
				end
			end else if (cnt_reg == half_next) begin
				cnt_reg <= '0;
				sck_o   <= ~sck_o;
				fall_o  <= sck_o;
				rise_o  <= ~sck_o;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

endmodule : ssio_sckgen

// File: hdl/ssio_top.sv
/*
 * ssio_top: 8-bit clocked synchronous serial unit with a classic
 * Wishbone register slave, internal or external serial clock.
 * Assumes pins arrive asynchronously; the pad resolves sck from oe.
 */
// The register addresses and the Wishbone register port are this design's own decisions.
module ssio_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        serial_clock_pin_i,
	output logic             serial_clock_pin_o,
	output logic             serial_clock_pin_oe_o,
	input  wire logic        serial_data_in_pin_i,
	output logic             serial_data_out_pin_o,
	output logic             serial_interrupt_request_o
);

	// address match, used by every access path
	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		hit = (a[3:2] == o[3:2]);
	endfunction : hit

	logic [7:0]  ctrl_reg;       // serial_control_reg
	logic [7:0]  tx_buf_reg;     // transmit_buffer
	logic [7:0]  rx_buf_reg;     // receive_buffer
	logic [7:0]  shift_reg;      // common tx/rx shifter
	logic        tx_full_reg;    // tx buffer holds unsent data
	logic        busy_reg;       // transfer_busy_flag
	logic        sact_reg;       // shift_active_flag
	logic        txe_reg;        // transmit_empty_flag
	logic        rxf_reg;        // receive_full_flag
	logic        transmit_error_flag_reg;      // transmit_error_flag
	logic        receive_error_flag_reg;      // receive_error_flag
	logic        txe_pend_reg;   // set empty at next rise
	logic        irq_pend_reg;   // raise request at next fall
	logic        rd_second_reg;  // error reads: next returns shifter
	logic [2:0]  bit_reg;        // rising edges seen in this byte
	logic        ext_sck_oe_reg; // registered pad direction
	logic        so_reg;         // data-out pin level
	logic        irq_reg;        // one-cycle request pulse
	ssio_pkg::ssio_state_t state_reg;

	logic        sck_s1_reg, sck_s2_reg, sck_s3_reg; // clock sync
	logic        si_s1_reg, si_s2_reg;               // data sync

	logic        gen_sck, gen_fall, gen_rise; // generator outputs
	logic        ext_fall, ext_rise;          // pin edges
	logic        fall_p, rise_p;              // selected edges
	logic        take;                        // bus request taken
	logic        wr_ctrl, wr_stat, wr_tx, rd_rx;
	logic        ext_clk, msb_first, start, inhibit;
	logic [1:0]  mode;
	logic        mode_ok, uses_tx, uses_rx, ready, gen_run;
	logic        begin_byte, end_byte, sample_bit;

	// control decode
	assign start     = ctrl_reg[ssio_pkg::CTRL_START];
	assign inhibit   = ctrl_reg[ssio_pkg::CTRL_INHIBIT];
	assign mode      = ctrl_reg[ssio_pkg::CTRL_MODE_HI:ssio_pkg::CTRL_MODE_LO];
	assign msb_first = ~ctrl_reg[ssio_pkg::CTRL_ORDER];
	assign ext_clk   = ctrl_reg[ssio_pkg::CTRL_CLK_HI:ssio_pkg::CTRL_CLK_LO]
	                   == ssio_pkg::CLK_EXTERNAL;
	assign uses_tx   = (mode == ssio_pkg::MODE_TX)
	                 | (mode == ssio_pkg::MODE_DUPLEX);
	assign uses_rx   = (mode == ssio_pkg::MODE_RX)
	                 | (mode == ssio_pkg::MODE_DUPLEX);
	assign mode_ok   = uses_tx | uses_rx; // code 11 never starts

	// internal clock may run a new byte only with buffers serviced
	assign ready = (~uses_tx | tx_full_reg)
	             & (~uses_rx | ~rxf_reg);
	assign gen_run = ~ext_clk & ~inhibit & ((state_reg == ssio_pkg::ST_SHIFT)
	               | (start & mode_ok & ready));

	// internal clock source
	ssio_sckgen u_sckgen (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.run_i  (gen_run),
		.rate_i (ctrl_reg[ssio_pkg::CTRL_CLK_HI:ssio_pkg::CTRL_CLK_LO]),
		.sck_o  (gen_sck),
		.fall_o (gen_fall),
		.rise_o (gen_rise)
	);

	// pin synchronisers; edges only from the second stage onward
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sck_s1_reg <= 1'b1;
			sck_s2_reg <= 1'b1;
			sck_s3_reg <= 1'b1;
			si_s1_reg  <= 1'b1;
			si_s2_reg  <= 1'b1;
		end else if (ce_i) begin
			sck_s1_reg <= serial_clock_pin_i;
			sck_s2_reg <= sck_s1_reg;
			sck_s3_reg <= sck_s2_reg;
			si_s1_reg  <= serial_data_in_pin_i;
			si_s2_reg  <= si_s1_reg;
		end
	end

	assign ext_fall = sck_s3_reg & ~sck_s2_reg;
	assign ext_rise = ~sck_s3_reg & sck_s2_reg;
	assign fall_p   = ce_i & ~inhibit & (ext_clk ? ext_fall : gen_fall);
	assign rise_p   = ce_i & ~inhibit & (ext_clk ? ext_rise : gen_rise);

	// byte framing events
	assign begin_byte = fall_p & (state_reg != ssio_pkg::ST_SHIFT)
	                  & start & mode_ok;
	assign end_byte   = rise_p & (state_reg == ssio_pkg::ST_SHIFT)
	                  & (bit_reg == ssio_pkg::LAST_BIT);
	assign sample_bit = rise_p & (state_reg == ssio_pkg::ST_SHIFT);

	// bus decode; one request per cycle of cyc&stb before ack
	assign take    = ce_i & wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_ctrl = take & wb_we_i & wb_sel_i[0] & hit(wb_adr_i,
	                 ssio_pkg::OFF_CTRL);
	assign wr_stat = take & wb_we_i & wb_sel_i[0] & hit(wb_adr_i,
	                 ssio_pkg::OFF_STAT);
	assign wr_tx   = take & wb_we_i & wb_sel_i[0] & hit(wb_adr_i,
	                 ssio_pkg::OFF_TXBUF);
	assign rd_rx   = take & ~wb_we_i & hit(wb_adr_i, ssio_pkg::OFF_RXBUF);

	// bus acknowledge and read data, one wait state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= take;
			wb_dat_o <= '0; // unmapped reads as zero
			if (take & ~wb_we_i) begin
				if (hit(wb_adr_i, ssio_pkg::OFF_CTRL))
					wb_dat_o[7:0] <= ctrl_reg;
				else if (hit(wb_adr_i, ssio_pkg::OFF_STAT))
					wb_dat_o[5:0] <= {receive_error_flag_reg, transmit_error_flag_reg, rxf_reg,
					                  txe_reg, sact_reg, busy_reg};
				else if (hit(wb_adr_i, ssio_pkg::OFF_TXBUF))
					wb_dat_o[7:0] <= tx_buf_reg;
				else if (rd_second_reg)
					wb_dat_o[7:0] <= shift_reg;
				else
					wb_dat_o[7:0] <= rx_buf_reg;
			end
		end
	end

	// control register; inhibit also clears start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= ssio_pkg::CTRL_RESET;
		end else if (ce_i) begin
			if (wr_ctrl)
				ctrl_reg <= wb_dat_i[7:0];
			else if (inhibit)
				ctrl_reg[ssio_pkg::CTRL_START] <= 1'b0;
			if (wr_ctrl & wb_dat_i[ssio_pkg::CTRL_INHIBIT])
				ctrl_reg[ssio_pkg::CTRL_START] <= 1'b0;
		end
	end

	// sequencer and bit counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ssio_pkg::ST_IDLE;
			bit_reg   <= '0;
			busy_reg  <= 1'b0;
		end else if (ce_i) begin
			if (inhibit) begin
				state_reg <= ssio_pkg::ST_IDLE;
				bit_reg   <= '0;
				busy_reg  <= 1'b0;
			end else begin
				case (state_reg)
				ssio_pkg::ST_IDLE, ssio_pkg::ST_WAIT: begin
					if (begin_byte) begin
						state_reg <= ssio_pkg::ST_SHIFT;
						busy_reg  <= 1'b1;
						bit_reg   <= '0;
					end else if (!start) begin
						// parked between bytes and stopped
						state_reg <= ssio_pkg::ST_IDLE;
						busy_reg  <= 1'b0;
					end
				end
				ssio_pkg::ST_SHIFT: begin
					if (rise_p)
						bit_reg <= bit_reg + 1'b1;
					if (end_byte) begin
						// a byte in progress completes with start cleared; only inhibit aborts it
						state_reg <= start ? ssio_pkg::ST_WAIT
						                   : ssio_pkg::ST_IDLE;
						busy_reg  <= start;
					end
				end
				default: state_reg <= ssio_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// shift active window: first fall to eighth fall
	always_ff @(posedge clk_i) begin
		if (rst_i | inhibit)
			sact_reg <= 1'b0;
		else if (ce_i) begin
			if (begin_byte)
				sact_reg <= 1'b1;
			else if (fall_p & (bit_reg == ssio_pkg::LAST_BIT))
				sact_reg <= 1'b0;
		end
	end

	// transmit buffer and its empty/full bookkeeping
	always_ff @(posedge clk_i) begin
		if (rst_i | inhibit) begin
			tx_buf_reg   <= ssio_pkg::BUF_RESET;
			tx_full_reg  <= 1'b0;
			txe_reg      <= ssio_pkg::TXEMPTY_INIT;
			txe_pend_reg <= 1'b0;
			transmit_error_flag_reg    <= 1'b0;
		end else if (ce_i) begin
			if (wr_tx) begin
				tx_buf_reg  <= wb_dat_i[7:0];
				tx_full_reg <= 1'b1;
				txe_reg     <= 1'b0;
			end
			if (begin_byte & uses_tx) begin
				if (tx_full_reg) begin
					tx_full_reg  <= 1'b0;
					txe_pend_reg <= 1'b1;
				end else
					transmit_error_flag_reg <= 1'b1;
			end
			if (rise_p & txe_pend_reg) begin
				txe_pend_reg <= 1'b0;
				txe_reg      <= 1'b1;
			end
		end
	end

	// shifter: load and drive on falls, sample on rises
	always_ff @(posedge clk_i) begin
		if (rst_i | inhibit) begin
			shift_reg <= ssio_pkg::BUF_RESET;
			so_reg    <= 1'b1;
		end else if (ce_i) begin
			if (begin_byte & uses_tx & tx_full_reg) begin
				shift_reg <= tx_buf_reg;
				so_reg    <= msb_first ? tx_buf_reg[7] : tx_buf_reg[0];
			end else if (fall_p & (state_reg == ssio_pkg::ST_SHIFT)
			             & uses_tx)
				so_reg <= msb_first ? shift_reg[7] : shift_reg[0];
			else if (end_byte)
				so_reg <= 1'b1;
			if (sample_bit & ~receive_error_flag_reg) begin
				if (msb_first)
					shift_reg <= {shift_reg[6:0], si_s2_reg};
				else
					shift_reg <= {si_s2_reg, shift_reg[7:1]};
			end
			// the first bit loads while busy is still low; keep it
			if (transmit_error_flag_reg | ~uses_tx | (~busy_reg & ~begin_byte))
				so_reg <= 1'b1;
		end
	end

	// receive buffer, full and error flags
	always_ff @(posedge clk_i) begin
		if (rst_i | inhibit) begin
			rx_buf_reg    <= ssio_pkg::BUF_RESET;
			rxf_reg       <= 1'b0;
			receive_error_flag_reg     <= 1'b0;
			rd_second_reg <= 1'b0;
		end else if (ce_i) begin
			if (rd_rx & ~receive_error_flag_reg)
				rxf_reg <= 1'b0;
			if (rd_rx & receive_error_flag_reg)
				rd_second_reg <= 1'b1;
			if (wr_stat & wb_dat_i[ssio_pkg::STAT_RECEIVE_ERROR_FLAG]) begin
				receive_error_flag_reg     <= 1'b0;
				rxf_reg       <= 1'b0;
				rd_second_reg <= 1'b0;
			end
			// completion after the clears: the set wins
			if (end_byte & uses_rx & ~receive_error_flag_reg) begin
				if (rxf_reg & ~rd_rx)
					receive_error_flag_reg <= 1'b1;
				else begin
					rx_buf_reg <= msb_first
					            ? {shift_reg[6:0], si_s2_reg}
					            : {si_s2_reg, shift_reg[7:1]};
					rxf_reg    <= 1'b1;
				end
			end
		end
	end

	// interrupt request pulse
	always_ff @(posedge clk_i) begin
		if (rst_i | inhibit) begin
			irq_reg      <= 1'b0;
			irq_pend_reg <= 1'b0;
		end else if (ce_i) begin
			irq_reg <= 1'b0;
			if (rise_p & txe_pend_reg & (mode == ssio_pkg::MODE_TX))
				irq_pend_reg <= 1'b1;
			if (begin_byte & uses_tx & ~tx_full_reg & ~receive_error_flag_reg)
				irq_pend_reg <= 1'b1;
			if (fall_p & irq_pend_reg & ~receive_error_flag_reg) begin
				irq_reg      <= 1'b1;
				irq_pend_reg <= 1'b0;
			end
			if (end_byte & uses_rx & ~receive_error_flag_reg)
				irq_reg <= 1'b1;
			if (receive_error_flag_reg)
				irq_reg <= 1'b0;
		end
	end

	// pad direction: drive the clock pin only on internal clock
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ext_sck_oe_reg <= 1'b0;
		else if (ce_i)
			ext_sck_oe_reg <= ~ext_clk;
	end

	assign serial_clock_pin_o         = gen_sck;
	assign serial_clock_pin_oe_o      = ext_sck_oe_reg;
	assign serial_data_out_pin_o      = so_reg;
	assign serial_interrupt_request_o = irq_reg;

	// checks
	localparam int AST_SCK_WAIT = 600;

	sequence seq_start_fall;
		busy_reg ##0 $past(fall_p);
	endsequence

	AST_BUSY_ON_FALL: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(busy_reg) |-> seq_start_fall)
		else $error("busy rose without a falling serial edge");

	AST_INHIBIT_INIT: assert property (@(posedge clk_i) disable iff (rst_i)
		(inhibit && ce_i) |=> (!start && !busy_reg && !rxf_reg && !receive_error_flag_reg
		&& !transmit_error_flag_reg && txe_reg && rx_buf_reg == '0 && tx_buf_reg == '0))
		else $error("inhibit did not initialise the unit");

	AST_TRANSMIT_ERROR_FLAG_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
		(transmit_error_flag_reg && ce_i) |=> serial_data_out_pin_o)
		else $error("data out low during transmit error");

	AST_IDLE_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
		(!busy_reg && !begin_byte && ce_i) |=> serial_data_out_pin_o)
		else $error("data out low while not busy");

	AST_RX_FULL_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(rxf_reg) |-> serial_interrupt_request_o)
		else $error("receive full without a request");

	AST_NO_IRQ_RECEIVE_ERROR_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
		(receive_error_flag_reg && $past(receive_error_flag_reg)) |-> !serial_interrupt_request_o)
		else $error("request while receive error stands");

	AST_READ_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_rx && !receive_error_flag_reg && !end_byte && !inhibit) |=> !rxf_reg)
		else $error("receive buffer read left full set");

	AST_RECEIVE_ERROR_FLAG_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
		(receive_error_flag_reg && $past(receive_error_flag_reg) && !inhibit)
		|-> $stable(rx_buf_reg))
		else $error("receive buffer changed under receive error");

	AST_SAMPLE_MSB: assert property (@(posedge clk_i) disable iff (rst_i)
		(sample_bit && msb_first && !receive_error_flag_reg && !inhibit
		&& !(begin_byte && uses_tx))
		|=> shift_reg[0] == $past(si_s2_reg))
		else $error("input bit not sampled on rising edge");

	AST_SACT_FALL: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(sact_reg) && !$past(inhibit) |-> $past(fall_p)
		&& $past(bit_reg) == ssio_pkg::LAST_BIT)
		else $error("shift active fell off the eighth fall");

	AST_INT_START: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == ssio_pkg::ST_IDLE && gen_run && ce_i)
		|-> ##[1:AST_SCK_WAIT] (gen_fall || !gen_run))
		else $error("internal clock did not start in time");

endmodule : ssio_top

// File: tb/ssio_peer.sv
/*
 * ssio_peer: behavioural far-side serial peer for the bench.
 * Assumes the bench resolves the clock pin from the device enable.
 */
module ssio_peer (
	input  wire logic pin_sck_i, // resolved clock pin level
	input  wire logic sdo_i,     // device data out
	output logic      sck_o,     // peer clock drive, idles high
	output logic      sdi_o      // data towards the device
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       follow; // answer the device clock instead
	logic [7:0] txd;    // byte offered in follow mode
	logic       lsb;    // bit order in follow mode
	int         idx;    // bit counter in follow mode

	// clock stands high between frames
	initial begin
		sck_o = 1'b1;
		sdi_o = 1'b0;
		follow = 1'b0;
		txd = 8'h00;
		lsb = 1'b0;
		idx = 0;
	end

	// one byte on our own clock, 400 ns period
	task automatic xfer(input logic [7:0] d, input logic l,
		output logic [7:0] q);
		q = 8'h00;
		#13; // phase kept unrelated to the system clock
		for (int i = 0; i < 8; i++) begin
			sck_o = 1'b0;
			sdi_o = l ? d[i] : d[7 - i];
			#200;
			sck_o = 1'b1;
			#120; // well after the device output has moved
			q = l ? {sdo_i, q[7:1]} : {q[6:0], sdo_i};
			#80;
		end
		sdi_o = ~sdi_o; // released line shows no stale bit
	endtask : xfer

	// follow mode: next bit on each device fall
	always @(negedge pin_sck_i) begin
		if (follow) begin
			sdi_o = lsb ? txd[idx] : txd[7 - idx];
			idx = (idx + 1) % 8;
		end
	end
endmodule : ssio_peer

// File: tb/test_ssio_top.sv
/*
 * test_ssio_top: self-checking bench of the serial unit.
 * Assumes ssio_pkg, ssio_top and ssio_peer are compiled first.
 */
module test_ssio_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst, cyc, stb, we;   // clock, reset, bus strobes
	logic [3:0]  adr;                      // bus byte address
	logic [31:0] dat, dat_o;               // bus write and read data
	logic        ack, dsck, oe, sdi, sdo;  // bus answer and pins
	logic        psck, irq;                // peer clock, interrupt
	wire         pin = oe ? dsck : psck;   // resolved clock pin
	logic [7:0]  q, t, r, b1, b2;          // data under test
	logic [31:0] seed = 32'h61e65da4;      // lfsr state, fixed start
	int          fail_count = 0;
	int          checks = 0;
	int          irqs = 0;                 // interrupt pulses seen
	int          n0, n;

	ssio_top u_ssio_top (.clk_i(clk), .rst_i(rst), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.serial_clock_pin_i(pin), .serial_clock_pin_o(dsck),
		.serial_clock_pin_oe_o(oe), .serial_data_in_pin_i(sdi),
		.serial_data_out_pin_o(sdo), .serial_interrupt_request_o(irq));
	ssio_peer u_ssio_peer (.pin_sck_i(pin), .sdo_i(sdo), .sck_o(psck),
		.sdi_o(sdi));

	// 20 MHz system clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// count interrupt pulses, one per cycle high
	always @(posedge clk) begin
		if (irq === 1'b1) irqs++;
	end

	// next random byte
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction : rnd

	// expected control byte
	function automatic logic [7:0] ctl(input logic s, input logic [1:0] m,
		input logic o, input logic [2:0] c);
		return {c, o, m, 1'b0, s};
	endfunction : ctl

	task automatic chk(input logic [7:0] g, input logic [7:0] e,
		input string m);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask : chk

	// one classic cycle; waits for ack, never assumes latency
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [7:0] d, output logic [7:0] rq);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		k = 0;
		@(posedge clk);
		while (ack !== 1'b1 && k < 50) begin
			@(posedge clk);
			k++;
		end
		rq = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 50) chk(8'h00, 8'h01, "no bus answer");
	endtask : wb

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] x;
		wb(1'b1, a, d, x);
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		wb(1'b0, a, 8'h00, d);
	endtask : rd

	// inhibit pulse leaves everything initialised
	task automatic init();
		wr(ssio_pkg::OFF_CTRL, 8'h02);
		wr(ssio_pkg::OFF_CTRL, 8'h00);
	endtask : init

	// cycles until the generated clock falls, bounded
	task automatic wait_fall(output int c);
		c = 0;
		while (dsck !== 1'b0 && c < 100) begin
			@(posedge clk);
			c++;
		end
	endtask : wait_fall

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// watchdog well beyond the expected run
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		end_sim();
	end

	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		dat = 32'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(ssio_pkg::OFF_STAT, q);
		chk(q, 8'h04, "status after reset");
		// external duplex, both bit orders
		for (int o = 0; o < 2; o++) begin
			t = rnd();
			r = rnd();
			init();
			wr(ssio_pkg::OFF_TXBUF, t);
			n0 = irqs;
			wr(ssio_pkg::OFF_CTRL, ctl(1, 2'h2, o, 3'h7));
			@(posedge clk); // pad direction follows the control write
			chk({7'h00, oe}, 8'h00, "clock pin driven");
			u_ssio_peer.xfer(r, o, q);
			chk(q, t, "duplex byte out");
			rd(ssio_pkg::OFF_STAT, q);
			chk(q, 8'h0d, "duplex status");
			chk(irqs - n0, 1, "duplex interrupt");
			rd(ssio_pkg::OFF_RXBUF, q);
			chk(q, r, "duplex byte in");
			rd(ssio_pkg::OFF_STAT, q);
			chk(q, 8'h05, "full after read");
			wr(ssio_pkg::OFF_CTRL, ctl(0, 2'h2, o, 3'h7));
			$display("test duplex order %0d done", o);
		end
		// transmit, start cleared mid byte
		init();
		t = rnd();
		wr(ssio_pkg::OFF_TXBUF, t);
		wr(ssio_pkg::OFF_CTRL, ctl(1, 2'h0, 0, 3'h7));
		fork
			u_ssio_peer.xfer(rnd(), 0, q);
			begin
				repeat (30) @(posedge clk);
				wr(ssio_pkg::OFF_CTRL, ctl(0, 2'h0, 0, 3'h7));
			end
		join
		chk(q, t, "byte finished after stop");
		rd(ssio_pkg::OFF_STAT, q);
		chk(q, 8'h04, "idle after stop");
		chk({7'h00, sdo}, 8'h01, "output high after stop");
		$display("test transmit stop done");
		// transmit error: shift begins with no data
		init();
		n0 = irqs;
		wr(ssio_pkg::OFF_CTRL, ctl(1, 2'h0, 0, 3'h7));
		u_ssio_peer.xfer(rnd(), 0, q);
		chk(q, 8'hff, "output during error");
		rd(ssio_pkg::OFF_STAT, q);
		chk(q & 8'h10, 8'h10, "transmit error flag");
		chk(irqs - n0, 1, "transmit error interrupt");
		wr(ssio_pkg::OFF_CTRL, 8'h02);
		rd(ssio_pkg::OFF_STAT, q);
		chk(q, 8'h04, "status initialised");
		rd(ssio_pkg::OFF_CTRL, q);
		chk(q, 8'h02, "start initialised");
		rd(ssio_pkg::OFF_TXBUF, q);
		chk(q, 8'h00, "buffer initialised");
		$display("test transmit error done");
		// external receive overrun, lsb first
		wr(ssio_pkg::OFF_CTRL, 8'h00);
		b1 = rnd();
		b2 = rnd();
		n0 = irqs;
		wr(ssio_pkg::OFF_CTRL, ctl(1, 2'h1, 1, 3'h7));
		u_ssio_peer.xfer(b1, 1, q);
		repeat (8) @(posedge clk);
		u_ssio_peer.xfer(b2, 1, q);
		rd(ssio_pkg::OFF_STAT, q);
		chk(q, 8'h2d, "overrun status");
		wr(ssio_pkg::OFF_CTRL, ctl(0, 2'h1, 1, 3'h7));
		u_ssio_peer.xfer(rnd(), 1, q);
		rd(ssio_pkg::OFF_STAT, q);
		chk(q & 8'h01, 8'h00, "stopped after eight clocks");
		rd(ssio_pkg::OFF_RXBUF, q);
		chk(q, b1, "byte before error");
		rd(ssio_pkg::OFF_RXBUF, q);
		chk(q, b2, "shifter after error");
		// first byte and the overrun itself request, nothing after
		chk(irqs - n0, 2, "no interrupt under error");
		wr(ssio_pkg::OFF_STAT, 8'h20);
		rd(ssio_pkg::OFF_STAT, q);
		chk(q & 8'h28, 8'h00, "error clear clears full");
		$display("test receive overrun done");
		// internal receive, clock code 1
		init();
		r = rnd();
		u_ssio_peer.txd = r;
		u_ssio_peer.idx = 0;
		u_ssio_peer.follow = 1'b1;
		wr(ssio_pkg::OFF_CTRL, ctl(1, 2'h1, 0, 3'h1));
		wait_fall(n);
		chk({7'h00, n <= 9}, 8'h01, "clock start delay");
		chk({7'h00, oe}, 8'h01, "clock pin driven");
		n = 0;
		q = 8'h00;
		while (q[3] !== 1'b1 && n < 100) begin
			rd(ssio_pkg::OFF_STAT, q);
			n++;
		end
		chk(q & 8'h0a, 8'h08, "receive full");
		n = 0;
		repeat (30) begin
			@(posedge clk);
			if (dsck !== 1'b1) n++;
		end
		chk(n, 0, "clock parked");
		rd(ssio_pkg::OFF_RXBUF, q);
		chk(q, r, "internal byte in");
		wait_fall(n);
		chk({7'h00, n <= 9}, 8'h01, "clock resumes");
		u_ssio_peer.follow = 1'b0;
		init();
		$display("test internal receive done");
		end_sim();
	end
endmodule : test_ssio_top
